// ==== clk_sel_if.sv ====
// Link between the reset sequencer and the clock switch.
// Both ends run on the same system clock.
`timescale 1ns/1ps

interface clk_sel_if;
  logic safeguardEn;
  logic stopReq;
  logic intTick;
  logic mainAlive;
  logic backupOn;
  logic useBackup;

  modport seq (output safeguardEn, stopReq,
               input  intTick, mainAlive, backupOn, useBackup);
  modport sw  (input  safeguardEn, stopReq,
               output intTick, mainAlive, backupOn, useBackup);
endinterface

// ==== clock_switch.sv ====
// Main oscillator watch, backup oscillator and glitch-free selection.
// Main oscillator level arrives synchronous to clock.
`timescale 1ns/1ps
`include "rsq_params.svh"

module clock_switch #(
  parameter int MISS_CYCLES = `MISS_CYC,
  parameter int BACKUP_LOW_FREQ_OSC_CYCLES = `BACKUP_LOW_FREQ_OSC_CYC
) (
  input  wire logic clock,
  input  wire logic resetn,
  input  wire logic mainOscIn,
  clk_sel_if.sw     bus
);

  rsq_pkg::sw_state_t s_q;
  rsq_pkg::sw_state_t s_d;
  logic               mainEdge;
  logic               stopped;
  logic               mainTick;
  logic               backupTick;
  logic               want;

  // Source events
  assign mainEdge   = mainOscIn & ~s_q.mainPrev;
  assign stopped    = bus.safeguardEn & bus.stopReq;
  assign mainTick   = mainEdge & ~stopped;
  assign backupTick = s_q.backupOn &
                      (s_q.divCnt == `DIV_W'(BACKUP_LOW_FREQ_OSC_CYCLES - 1));
  assign want       = bus.safeguardEn & (s_q.mainGone | stopped);

  // Next state
  always_comb begin
    s_d = s_q;
    s_d.mainPrev = mainOscIn;
    if (mainEdge) begin
      s_d.missCnt  = '0;
      s_d.mainGone = 1'b0;
    end else if (s_q.missCnt == `DIV_W'(MISS_CYCLES - 1)) begin
      s_d.mainGone = 1'b1;
    end else begin
      s_d.missCnt = s_q.missCnt + 1'b1;
    end
    s_d.backupOn = want;
    if (!s_q.backupOn || backupTick) begin
      s_d.divCnt = '0;
    end else begin
      s_d.divCnt = s_q.divCnt + 1'b1;
    end
    // Swap only on an edge of the incoming source
    if (want && backupTick) begin
      s_d.useBackup = 1'b1;
    end else if (!want && mainTick) begin
      s_d.useBackup = 1'b0;
    end
  end

  // State register; main assumed absent, no false edge after reset
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_q <= '{mainPrev: 1'b1, missCnt: '0, mainGone: 1'b1,
               backupOn: 1'b0, divCnt: '0, useBackup: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  // Internal clock tick from the selected source
  assign bus.intTick   = s_d.useBackup ? backupTick : mainTick;
  assign bus.mainAlive = ~s_q.mainGone;
  assign bus.backupOn  = s_q.backupOn;
  assign bus.useBackup = s_q.useBackup;

  localparam int LfaoBound = BACKUP_LOW_FREQ_OSC_CYCLES;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  chk_backup_option: assert property (
    !bus.safeguardEn |=> !s_q.backupOn)
    else $error("backup oscillator runs without safeguard");

  chk_backup_start: assert property (
    $rose(s_q.backupOn) |-> ##[1:LfaoBound]
      (bus.intTick || !s_q.backupOn))
    else $error("backup oscillator gave no tick in one period");

  chk_backup_stop: assert property (
    (mainEdge && !stopped) ##1 !stopped |=> !s_q.backupOn)
    else $error("backup oscillator not stopped by main edge");

endmodule

// ==== osc_board_model.sv ====
// Board side model: main crystal and the reset pin with its pull-up.
// Assumes its controls change just after a rising clock edge.
`timescale 1ns/1ps

module osc_board_model #(
  parameter int HALF = 2
) (
  input  wire logic clock,
  input  wire logic oscEnable,
  input  wire logic oscHealthy,
  input  wire logic buttonLow,
  input  wire logic resetPinOut,
  input  wire logic resetPinOe,
  output logic      mainOscIn,
  output logic      resetPinIn
);
  int phaseCnt;

  // Pull-up wins unless the device or the board button pulls low
  assign resetPinIn = (resetPinOe ? resetPinOut : 1'b1) & ~buttonLow;

  // Crystal toggles while enabled and healthy, else stands still
  initial begin
    mainOscIn = 1'b0;
    phaseCnt = 0;
  end
  always @(posedge clock) begin
    if (oscEnable && oscHealthy) begin
      phaseCnt <= (phaseCnt == HALF - 1) ? 0 : phaseCnt + 1;
      if (phaseCnt == HALF - 1) begin
        mainOscIn <= ~mainOscIn;
      end
    end
  end
endmodule

// ==== reset_seq_top.sv ====
// Reset and backup clock sequencer with its APB register slave.
// Pins and option bits are synchronous to clock; APB uses byte addresses.
//
// Summary of operation
// - Backup oscillator only with safeguard option.
// - Backup starts within one period of loss.
// - Power-on delay counts backup, then main ticks.
// - Backup stops once main oscillator runs.
// - Control bit 2 stops main, forcing backup.
// - Stop bit ignored without safeguard option.
// - Low supply holds static reset while enabled.
// - Low-voltage reset drives reset pin low.
// - Reset from pin, watchdog or low voltage.
// - Wait 2048 internal ticks before vector fetch.
// - Vector fetch lasts exactly two ticks.
// - Reset clears the whole return stack.
// - Program counter loads top reset vector.
// - Reset enters non-maskable interrupt mode.
// - Short pin pulse stretched by full delay.
// - Held while pin low; delay after release.
// - Pin reset in run restarts main oscillator.
// - Pin reset in stop starts oscillator too.
// - Unrefreshed watchdog end-of-count causes reset.
// - Watchdog reset restarts like pin reset.
// - Watchdog reset pulses pin low briefly.
`timescale 1ns/1ps
`include "rsq_params.svh"

module reset_seq_top #(
  parameter int DELAY_TICKS = `DELAY_CYC,
  parameter int FETCH_TICKS = `FETCH_CYC,
  parameter int MISS_CYCLES = `MISS_CYC,
  parameter int BACKUP_LOW_FREQ_OSC_CYCLES = `BACKUP_LOW_FREQ_OSC_CYC
) (
  input  wire logic        clock,
  input  wire logic        resetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Reset pin, open drain
  input  wire logic        resetPinIn,
  output logic             resetPinOut,
  output logic             resetPinOe,
  // Reset sources and option bits
  input  wire logic        wdgEndCount,
  input  wire logic        supplyLow,
  input  wire logic        lvdOptionEn,
  input  wire logic        safeguardOptionEn,
  // Main oscillator
  input  wire logic        mainOscIn,
  output logic             mainOscEnable,
  // Internal clock
  output logic             intClkTick,
  output logic             backupOscOn,
  // Core side
  output logic             coreResetN,
  output logic             vectorFetch,
  output logic             pcLoad,
  output logic      [11:0] pcValue,
  output logic             stackClear,
  output logic             nmiModeSet,
  output logic             portsToInput
);

  rsq_pkg::seq_state_t s_q;
  rsq_pkg::seq_state_t s_d;
  clk_sel_if           sel ();

  logic pinLow;
  logic lvdLow;
  logic hold;
  logic newEvent;
  logic setup;
  logic access;
  logic hitCtrl;
  logic hitStat;
  logic tick;
  logic stopBit;

  // Clock selection and backup oscillator
  clock_switch #(
    .MISS_CYCLES (MISS_CYCLES),
    .BACKUP_LOW_FREQ_OSC_CYCLES (BACKUP_LOW_FREQ_OSC_CYCLES)
  ) u_switch (
    .clock     (clock),
    .resetn    (resetn),
    .mainOscIn (mainOscIn),
    .bus       (sel.sw)
  );

  // Reset sources
  assign pinLow   = ~resetPinIn;
  assign lvdLow   = lvdOptionEn & supplyLow;
  assign hold     = pinLow | lvdLow;
  assign newEvent = hold | wdgEndCount;
  assign tick     = sel.intTick;

  // Oscillator control from the register
  assign stopBit         = s_q.ctrl[`STOP_BIT];
  assign sel.safeguardEn = safeguardOptionEn;
  assign sel.stopReq     = stopBit;
  assign mainOscEnable   = ~(safeguardOptionEn & stopBit);

  // APB decode
  assign setup   = psel & ~penable;
  assign access  = psel & penable;
  always_comb begin
    hitCtrl = 1'b0;
    hitStat = 1'b0;
    if (paddr[1:0] != 2'h0) begin
      hitCtrl = 1'b0;
    end else if (paddr[11:2] == `CTRL_IDX) begin
      hitCtrl = 1'b1;
    end else if (paddr[11:2] == `STAT_IDX) begin
      hitStat = 1'b1;
    end
  end

  // Next state
  always_comb begin
    s_d      = s_q;
    s_d.load = 1'b0;

    // Watchdog flag pulse on the pin
    if (wdgEndCount) begin
      s_d.pulse = `PULSE_W'(`WDG_PULSE_CYC);
    end else if (s_q.pulse != '0) begin
      s_d.pulse = s_q.pulse - 1'b1;
    end

    // Register write, then reset events override
    if (access && pwrite && hitCtrl) begin
      s_d.ctrl = pwdata[7:0];
    end
    if (newEvent) begin
      s_d.ctrl = `CTRL_RST;
    end

    // Latest reset cause
    if (lvdLow) begin
      s_d.cause = `CAUSE_LVD;
    end else if (pinLow && s_q.pulse == '0) begin // Not our own pulse
      s_d.cause = `CAUSE_PIN;
    end else if (wdgEndCount) begin
      s_d.cause = `CAUSE_WDG;
    end

    // Sequence
    case (s_q.phase)
      rsq_pkg::PH_HOLD: begin
        s_d.cnt = '0;
        if (!hold) begin
          s_d.phase = rsq_pkg::PH_DELAY;
        end
      end
      rsq_pkg::PH_DELAY: begin
        if (tick) begin
          if (s_q.cnt == `CNT_W'(DELAY_TICKS - 1)) begin
            s_d.phase = rsq_pkg::PH_FETCH;
            s_d.cnt   = '0;
            s_d.load  = 1'b1;
          end else begin
            s_d.cnt = s_q.cnt + 1'b1;
          end
        end
      end
      rsq_pkg::PH_FETCH: begin
        if (tick) begin
          if (s_q.cnt == `CNT_W'(FETCH_TICKS - 1)) begin
            s_d.phase = rsq_pkg::PH_RUN;
            s_d.cnt   = '0;
          end else begin
            s_d.cnt = s_q.cnt + 1'b1;
          end
        end
      end
      default: begin
        s_d.cnt = '0;
      end
    endcase

    // Any event restarts the sequence from zero
    if (hold) begin
      s_d.phase = rsq_pkg::PH_HOLD;
      s_d.cnt   = '0;
      s_d.load  = 1'b0;
    end else if (wdgEndCount) begin
      s_d.phase = rsq_pkg::PH_DELAY;
      s_d.cnt   = '0;
      s_d.load  = 1'b0;
    end

    // Read data captured in the setup cycle
    if (setup) begin
      if (hitCtrl) begin
        s_d.rdata = {24'h0, s_q.ctrl};
      end else if (hitStat) begin
        s_d.rdata = {25'h0, s_q.phase, sel.mainAlive,
                     sel.backupOn, sel.useBackup, s_q.cause};
      end else begin
        s_d.rdata = '0;
      end
    end
  end

  // State register
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_q <= '{phase: rsq_pkg::PH_HOLD, cnt: '0, ctrl: `CTRL_RST,
               pulse: '0, cause: `CAUSE_NONE, load: 1'b0,
               rdata: '0};
    end else begin
      s_q <= s_d;
    end
  end

  // APB answer: one wait-free access phase
  assign prdata  = s_q.rdata;
  assign pready  = 1'b1;
  assign pslverr = access & ~(hitCtrl | hitStat);

  // Reset pin drive, low only
  assign resetPinOut = 1'b0;
  assign resetPinOe  = lvdLow | (s_q.pulse != '0);

  // Internal clock
  assign intClkTick  = tick;
  assign backupOscOn = sel.backupOn;

  // Core controls
  assign coreResetN   = (s_q.phase == rsq_pkg::PH_RUN);
  assign vectorFetch  = (s_q.phase == rsq_pkg::PH_FETCH);
  assign pcLoad       = s_q.load;
  assign pcValue      = `PC_VECTOR;
  assign stackClear   = s_q.load;
  assign nmiModeSet   = s_q.load;
  assign portsToInput = (s_q.phase != rsq_pkg::PH_RUN);

  // Ticks seen in the current phase, for checking only
  logic [`CNT_W:0] phaseTicks;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      phaseTicks <= '0;
    end else if (s_d.phase != s_q.phase || newEvent) begin
      phaseTicks <= '0;
    end else if (tick) begin
      phaseTicks <= phaseTicks + 1'b1;
    end
  end

  localparam int PulseLen = `WDG_PULSE_CYC;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  chk_pin_hold: assert property (
    pinLow |=> (s_q.phase == rsq_pkg::PH_HOLD) && !coreResetN)
    else $error("pin low did not hold reset");

  chk_delay_len: assert property (
    (s_q.phase == rsq_pkg::PH_DELAY) ##1
    (s_q.phase == rsq_pkg::PH_FETCH)
    |-> $past(phaseTicks) == (`CNT_W+1)'(DELAY_TICKS - 1))
    else $error("reset delay length wrong");

  chk_fetch_len: assert property (
    (s_q.phase == rsq_pkg::PH_FETCH) ##1
    (s_q.phase == rsq_pkg::PH_RUN)
    |-> $past(phaseTicks) == (`CNT_W+1)'(FETCH_TICKS - 1))
    else $error("vector fetch length wrong");

  chk_vector_load: assert property (
    $rose(vectorFetch) |-> pcLoad && pcValue == `PC_VECTOR
      ##1 !pcLoad)
    else $error("reset vector not loaded on fetch entry");

  chk_nmi_stack: assert property (
    pcLoad |-> stackClear && nmiModeSet && !coreResetN)
    else $error("stack clear or nmi mode missing");

  chk_lvd_pin: assert property (
    lvdLow |-> resetPinOe && !resetPinOut
      ##1 s_q.phase == rsq_pkg::PH_HOLD)
    else $error("low voltage did not drive pin and hold");

  chk_wdg_pulse: assert property (
    (wdgEndCount && !lvdLow) |=> resetPinOe[*6])
    else $error("watchdog pin pulse too short");

  chk_wdg_restart: assert property (
    (wdgEndCount && !hold) |=> s_q.phase == rsq_pkg::PH_DELAY
      && s_q.cnt == '0)
    else $error("watchdog did not restart delay");

  chk_osc_stop: assert property (
    !safeguardOptionEn |-> mainOscEnable ##1
      (!s_q.ctrl[`STOP_BIT] || mainOscEnable || safeguardOptionEn))
    else $error("stop bit acted without safeguard");

  chk_stop_backup: assert property (
    (safeguardOptionEn && stopBit) |-> !mainOscEnable
      ##2 (sel.backupOn || !stopBit || !safeguardOptionEn))
    else $error("stop did not start backup oscillator");

  chk_ctrl_reload: assert property (
    newEvent |=> s_q.ctrl == `CTRL_RST)
    else $error("reset event did not reload control");

  cov_lvd_hold: cover property (
    lvdLow ##1 s_q.phase == rsq_pkg::PH_HOLD);

  cov_reach_run: cover property (
    s_q.phase == rsq_pkg::PH_FETCH ##1 s_q.phase == rsq_pkg::PH_RUN);

  cov_wdg_reset: cover property (
    coreResetN ##1 wdgEndCount);

  cov_backup_swap: cover property (
    !sel.useBackup ##1 sel.useBackup);

  cov_pulse_len: cover property (
    resetPinOe && s_q.pulse == `PULSE_W'(PulseLen));

endmodule

// ==== rsq_params.svh ====
// Constants for the reset and backup clock sequencer.
// Assumes a 250 MHz system clock and a 12-bit APB byte address.
`ifndef RSQ_PARAMS_SVH
`define RSQ_PARAMS_SVH

// Clock period in ns
`define CLK_NS        4
// Register indexes; byte address is four times the index
`define CTRL_IDX      10'h0d1
`define STAT_IDX      10'h0d2
`define CTRL_RST      8'h40
`define STOP_BIT      2
// Reset vector and sequence lengths in internal clock ticks
`define PC_VECTOR     12'hffe
`define DELAY_CYC     2048
`define FETCH_CYC     2
// Watchdog flag pulse on the reset pin
`define WDG_PULSE_NS  24
`define WDG_PULSE_CYC (`WDG_PULSE_NS / `CLK_NS)
// Backup oscillator period and missing-edge timeout
`define BACKUP_LOW_FREQ_OSC_NS       4000
`define BACKUP_LOW_FREQ_OSC_CYC      (`BACKUP_LOW_FREQ_OSC_NS / `CLK_NS)
`define MISS_NS       1000
`define MISS_CYC      (`MISS_NS / `CLK_NS)
// Counter widths
`define CNT_W         12
`define DIV_W         10
`define PULSE_W       3
// Reset cause codes in the status register
`define CAUSE_NONE    2'h0
`define CAUSE_PIN     2'h1
`define CAUSE_WDG     2'h2
`define CAUSE_LVD     2'h3

`endif

// ==== rsq_pkg.sv ====
// Types shared by the sequencer and its clock switch.
// Widths come from rsq_params.svh.
`include "rsq_params.svh"

package rsq_pkg;

  typedef enum logic [1:0] {PH_HOLD, PH_DELAY, PH_FETCH, PH_RUN} phase_t;

  typedef struct packed {
    phase_t                 phase;
    logic [`CNT_W-1:0]      cnt;
    logic [7:0]             ctrl;
    logic [`PULSE_W-1:0]    pulse;
    logic [1:0]             cause;
    logic                   load;
    logic [31:0]            rdata;
  } seq_state_t;

  typedef struct packed {
    logic                   mainPrev;
    logic [`DIV_W-1:0]      missCnt;
    logic                   mainGone;
    logic                   backupOn;
    logic [`DIV_W-1:0]      divCnt;
    logic                   useBackup;
  } sw_state_t;

endpackage

// ==== testbench.sv ====
// Self-checking bench for the reset and backup clock sequencer.
// Assumes the design files and the board model are compiled first.
`timescale 1ns/1ps

module testbench;
  localparam int D = 8;
  localparam int F = 2;
  logic        clock, resetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr, pcValue;
  logic [31:0] pwdata, prdata, rd;
  logic        resetPinIn, resetPinOut, resetPinOe, wdgEndCount, supplyLow;
  logic        lvdOptionEn, safeguardOptionEn, mainOscIn, mainOscEnable;
  logic        intClkTick, backupOscOn, coreResetN, vectorFetch, pcLoad;
  logic        stackClear, nmiModeSet, portsToInput, button, healthy, err;
  logic        fetchGo, sgPrev;
  logic [7:0]  ctrlM;
  int          error_cnt, tests_run, cycles, ph, cnt, oeCnt, seed, i;

  reset_seq_top #(.DELAY_TICKS(D), .FETCH_TICKS(F), .MISS_CYCLES(8),
    .BACKUP_LOW_FREQ_OSC_CYCLES(10)) reset_seq_top_i (.clock(clock), .resetn(resetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .resetPinIn(resetPinIn), .resetPinOut(resetPinOut),
    .resetPinOe(resetPinOe), .wdgEndCount(wdgEndCount),
    .supplyLow(supplyLow), .lvdOptionEn(lvdOptionEn),
    .safeguardOptionEn(safeguardOptionEn), .mainOscIn(mainOscIn),
    .mainOscEnable(mainOscEnable), .intClkTick(intClkTick),
    .backupOscOn(backupOscOn), .coreResetN(coreResetN),
    .vectorFetch(vectorFetch), .pcLoad(pcLoad), .pcValue(pcValue),
    .stackClear(stackClear), .nmiModeSet(nmiModeSet),
    .portsToInput(portsToInput));

  osc_board_model osc_board_model_i (.clock(clock),
    .oscEnable(mainOscEnable), .oscHealthy(healthy), .buttonLow(button),
    .resetPinOut(resetPinOut), .resetPinOe(resetPinOe),
    .mainOscIn(mainOscIn), .resetPinIn(resetPinIn));

  // Clock and hang guard
  always #2 clock = ~clock;
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt = error_cnt + 1;
      print_verdict();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d, errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // One APB transfer; waits for pready, no fixed latency assumed
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    // Answer sampled while it stands, before the closing edge
    @(negedge clock);
    while (pready !== 1'b1) begin
      @(negedge clock);
    end
    rd = prdata;
    err = pslverr;
    @(posedge clock);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Bounded wait for a level, then compare it
  task automatic waitFor(ref logic s, input logic v, input int lim);
    int n;
    n = 0;
    @(negedge clock);
    while (s !== v && n < lim) begin
      n++;
      @(negedge clock);
    end
    check(s, v);
    @(posedge clock);
  endtask

  // Reference model: compare the last edge, then predict the next
  always @(negedge clock) begin
    if (!resetn) begin
      ph = 0;
      cnt = 0;
      oeCnt = 0;
      ctrlM = 8'h40;
      fetchGo = 0;
    end else begin
      check(coreResetN, ph == 3);
      check(vectorFetch, ph == 2);
      check(pcLoad, fetchGo);
      check(stackClear, fetchGo);
      check(nmiModeSet, fetchGo);
      check(portsToInput, ph != 3);
      check({pready, resetPinOut}, 2'b10);
      check(resetPinOe, (lvdOptionEn & supplyLow) | (oeCnt > 0));
      check(mainOscEnable, !(ctrlM[2] && safeguardOptionEn));
      if (fetchGo) check(pcValue, 12'hffe);
      if (!safeguardOptionEn && !sgPrev) check(backupOscOn, 0);
      fetchGo = 0;
      if (oeCnt > 0) oeCnt--;
      // Held while the pin is low or the supply is low with the option on
      if (!resetPinIn || (lvdOptionEn && supplyLow)) begin
        ph = 0;
        cnt = 0;
        ctrlM = 8'h40;
      end else if (wdgEndCount) begin
        ph = 1;
        cnt = 0;
        oeCnt = 6;
        ctrlM = 8'h40;
      end else begin
        if (psel && penable && pwrite && paddr == 12'h344) begin
          ctrlM = pwdata[7:0];
        end
        if (ph == 0) ph = 1;
        else if (ph < 3 && intClkTick) begin
          cnt++;
          if (cnt == (ph == 1 ? D : F)) begin
            ph++;
            cnt = 0;
            fetchGo = (ph == 2);
          end
        end
      end
    end
    sgPrev = safeguardOptionEn;
  end

  initial begin
    {resetn, psel, penable, pwrite, paddr, pwdata, button} = '0;
    {wdgEndCount, supplyLow, lvdOptionEn, healthy, sgPrev} = '0;
    {error_cnt, tests_run, cycles} = '0;
    safeguardOptionEn = 1'b1;
    seed = 69349;
    clock = 1'b0;
    repeat (8) @(posedge clock);
    resetn <= 1'b1;
    // Power-on with a dead crystal, then it starts mid-delay
    waitFor(backupOscOn, 1, 40);
    repeat (30) @(posedge clock);
    healthy <= 1'b1;
    waitFor(coreResetN, 1, 2000);
    waitFor(backupOscOn, 0, 40);
    // Register access, reserved address refused
    apb(0, 12'h344, 0);
    check(rd, 32'h40);
    check(err, 1'b0);
    apb(1, 12'h344, $random(seed) & 32'hfffffffb);
    apb(0, 12'h344, 0);
    check(rd, {24'h0, ctrlM});
    apb(0, 12'h400, 0);
    check(rd, 32'h0);
    check(err, 1'b1);
    // Stop bit with and without the safeguard option
    for (i = 1; i >= 0; i--) begin
      safeguardOptionEn <= i[0];
      apb(1, 12'h344, 32'h44);
      if (i == 1) waitFor(backupOscOn, 1, 60);
      apb(1, 12'h344, 32'h40);
      waitFor(backupOscOn, 0, 60);
    end
    safeguardOptionEn <= 1'b1;
    // Short pin pulse, then a long random hold
    for (i = 0; i < 2; i++) begin
      button <= 1'b1;
      repeat (i == 0 ? 1 : 10 + ($random(seed) & 15)) @(posedge clock);
      button <= 1'b0;
      waitFor(coreResetN, 1, 2000);
      apb(0, 12'h348, 0);
      check(rd & 32'h63, 32'h61);
    end
    // Watchdog reset, a second one restarts the delay
    for (i = 0; i < 2; i++) begin
      wdgEndCount <= 1'b1;
      @(posedge clock);
      wdgEndCount <= 1'b0;
      repeat (14) @(posedge clock);
    end
    waitFor(coreResetN, 1, 2000);
    apb(0, 12'h348, 0);
    check(rd & 32'h63, 32'h62);
    // Low supply ignored unless the option is on
    for (i = 0; i < 2; i++) begin
      lvdOptionEn <= i[0];
      supplyLow <= 1'b1;
      repeat (20) @(posedge clock);
      supplyLow <= 1'b0;
      waitFor(coreResetN, 1, 2000);
    end
    // Crystal fails in run; reset then runs on backup ticks
    healthy <= 1'b0;
    waitFor(backupOscOn, 1, 40);
    button <= 1'b1;
    @(posedge clock);
    button <= 1'b0;
    waitFor(coreResetN, 1, 2000);
    healthy <= 1'b1;
    waitFor(backupOscOn, 0, 60);
    // Second power-on reset in mid-run
    resetn <= 1'b0;
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    waitFor(coreResetN, 1, 2000);
    print_verdict();
  end
endmodule
